// ---- sim/asr_front_model.sv ----
/*
  asr_front_model: sample path, detection engines and queue feeding the bank.
  assumes: driven by bench tasks; all changes just after a rising edge.
*/
`timescale 1ns/1ps

module asr_front_model (
  // clock
  input  wire logic                ref_clk,
  // sensor side
  output logic                     sample_valid,
  output asr_pkg::asr_sample_t     sample_in,
  output logic [2:0]               events,
  output logic                     awake_state,
  output logic                     queue_overrun,
  output logic [asr_pkg::QCNT_W-1:0] queue_count
);
  initial begin
    sample_valid = 1'b0;
    sample_in = '0;
    events = 3'h0;
    {awake_state, queue_overrun, queue_count} = 12'h800;
  end
  // released sample shows its inverse
  task automatic push(input asr_pkg::asr_sample_t s);
    @(posedge ref_clk) {sample_valid, sample_in} <= {1'b1, s};
    @(posedge ref_clk) {sample_valid, sample_in} <= {1'b0, ~s};
  endtask : push
  // one-cycle pulse: 0 upset, 1 stillness, 2 motion
  task automatic pulse(input int k);
    @(posedge ref_clk) events <= 3'h1 << k;
    @(posedge ref_clk) events <= 3'h0;
  endtask : pulse
  task automatic levels(input logic aw, input logic ov, input logic [asr_pkg::QCNT_W-1:0] c);
    @(posedge ref_clk) {awake_state, queue_overrun, queue_count} <= {aw, ov, c};
  endtask : levels
endmodule : asr_front_model

// ---- sim/asr_regs_checker.sv ----
/*
  asr_regs_checker: bus timing and read-data relations of the register bank.
  assumes: bound to asr_regs, single ref_clk domain, 8-bit byte address.
*/
`timescale 1ns/1ps

module asr_regs_checker #(
  parameter int                         ADR_W     = 8,
  parameter logic [asr_pkg::QCNT_W-1:0] THR_RESET = 10'h000
) (
  // clock and reset
  input wire logic                         ref_clk,
  input wire logic                         resetn,
  // bus
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic [ADR_W-1:0]             wb_adr_i,
  input wire logic [31:0]                  wb_dat_o,
  input wire logic                         wb_ack_o,
  // sources
  input wire logic [asr_pkg::SERIAL_W-1:0] serial_number,
  input wire logic                         awake_state,
  input wire logic                         queue_overrun,
  input wire logic [asr_pkg::QCNT_W-1:0]   queue_count,
  input wire logic                         queue_write_block,
  input wire logic [1:0]                   detect_coupling_mode,
  input wire logic                         irq
);
  logic [5:0] idx;
  assign idx = wb_adr_i[7:2];

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence rd_ack(i);
    wb_ack_o && !$past(wb_we_i) && $past(idx) == i;
  endsequence

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  block_follow_a: assert property ($past(resetn) |-> queue_write_block == $past(queue_overrun))
    else $error("queue block not following overrun");
  overrun_bit_a: assert property (rd_ack(asr_pkg::IDX_STATUS) |-> wb_dat_o[3] == $past(queue_overrun))
    else $error("overrun status bit wrong");
  ready_bit_a: assert property (rd_ack(asr_pkg::IDX_STATUS) |-> wb_dat_o[1] == ($past(queue_count) != 0))
    else $error("queue ready bit wrong");
  awake_bit_a: assert property (rd_ack(asr_pkg::IDX_STATUS) |-> wb_dat_o[6] ==
    ($past(detect_coupling_mode) inside {2'h1, 2'h3} ? $past(awake_state) : 1'b1)) else $error("awake bit wrong");
  serial_top_a: assert property (rd_ack(asr_pkg::IDX_SERIAL3) |-> wb_dat_o == {28'h0, serial_number[27:24]})
    else $error("serial top nibble wrong");
  serial_mid_a: assert property (rd_ack(asr_pkg::IDX_SERIAL2) |-> wb_dat_o == {24'h0, serial_number[23:16]})
    else $error("serial byte two wrong");

  cover property (rd_ack(asr_pkg::IDX_STATUS));
  cover property (wb_ack_o && $past(wb_we_i));
  cover property ($rose(irq));
endmodule : asr_regs_checker

bind asr_regs asr_regs_checker #(.ADR_W(ADR_W), .THR_RESET(THR_RESET)) u_chk (.ref_clk, .resetn, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .serial_number, .awake_state, .queue_overrun,
  .queue_count, .queue_write_block, .detect_coupling_mode, .irq);

// ---- sim/tb_accel_status_sample_regs.sv ----
/*
  tb_accel_status_sample_regs: register reads and writes with expected values.
  assumes: asr_regs, asr_front_model and the bound checker are compiled.
*/
`timescale 1ns/1ps

module tb_accel_status_sample_regs;
  logic ref_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, queue_write_block, sample_valid;
  logic awake_state, queue_overrun;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i;
  logic [30:0] serial_number;
  logic [2:0] events;
  logic [1:0] mode;
  logic [9:0] queue_count;
  asr_pkg::asr_sample_t sample_in;
  int n_mismatch = 0, cmp_count = 0, cycles = 0;

  asr_regs dut (.ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .serial_number, .sample_valid, .sample_in, .config_upset(events[0]),
    .awake_state, .stillness_detected(events[1]), .motion_detected(events[2]), .queue_overrun, .queue_count,
    .queue_write_block, .detect_coupling_mode(mode), .irq);
  asr_front_model src (.ref_clk, .sample_valid, .sample_in, .events, .awake_state, .queue_overrun,
    .queue_count);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s = 4'hF);
    @(posedge ref_clk) {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, s, wd};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : rw

  task automatic ck(input logic [7:0] a, input logic [31:0] e);
    rw(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : ck

  initial begin
    {resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    serial_number = 31'h5A3C9E71;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    ck(8'h2C, 32'hC0);
    ck(8'h10, 32'h0A);
    ck(8'h14, 32'h3C);
    ck(8'h18, 32'h9E);
    ck(8'h1C, 32'h71);
    serial_number <= 31'h2D5A0F3C;
    ck(8'h10, 32'h0D);
    ck(8'h1C, 32'h3C);
    ck(8'h3C, 32'h0);
    rw(1'b1, 8'h14, 32'hFF);
    ck(8'h14, 32'h5A);
    ck(8'h2C, 32'h40);
    src.push({14'h2ABC, 14'h1FFF, 14'h0040});
    ck(8'h2C, 32'h41);
    ck(8'h20, 32'hAA);
    ck(8'h2C, 32'h40);
    ck(8'h24, 32'h7F);
    ck(8'h28, 32'h01);
    fork
      src.push({14'h0000, 14'h3FC0, 14'h0000});
      ck(8'h24, 32'h7F);
    join
    ck(8'h2C, 32'h41);
    ck(8'h24, 32'hFF);
    src.pulse(2);
    ck(8'h2C, 32'h50);
    src.pulse(1);
    ck(8'h2C, 32'h60);
    ck(8'h2C, 32'h40);
    src.pulse(0);
    ck(8'h2C, 32'hC0);
    rw(1'b1, 8'h80, 32'h301);
    chk({30'h0, mode}, 32'h1);
    ck(8'h80, 32'h301);
    src.levels(1'b0, 1'b1, 10'h3);
    ck(8'h2C, 32'h0A);
    chk({31'h0, queue_write_block}, 32'h1);
    src.levels(1'b0, 1'b1, 10'h4);
    ck(8'h2C, 32'h0E);
    rw(1'b1, 8'h80, 32'h0000_FF03, 4'h1);
    ck(8'h2C, 32'h0E);
    ck(8'h80, 32'h303);
    rw(1'b1, 8'h80, 32'h0);
    src.levels(1'b0, 1'b0, 10'h0);
    ck(8'h2C, 32'h40);
    ck(8'h84, 32'h1F);
    rw(1'b1, 8'h84, 32'h1F);
    rw(1'b1, 8'h88, 32'h02);
    ck(8'h88, 32'h02);
    chk({31'h0, irq}, 32'h0);
    src.pulse(1);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    src.pulse(2);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    ck(8'h84, 32'h06);
    rw(1'b1, 8'h84, 32'h02);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    ck(8'h2C, 32'hC0);
    ck(8'h20, 32'h00);
    chk({29'h0, mode, irq}, 32'h0);
    close_out;
  end
endmodule : tb_accel_status_sample_regs

// ---- verilog/asr_pkg.sv ----
/*
  asr_pkg: register indices, field positions, reset values and carrier types
  for the sensor status and sample register bank.
  assumes: byte address = 4 * register index on a 32-bit wishbone bus.
*/
package asr_pkg;

  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_SERIAL3   = 6'h04;
  localparam logic [5:0] IDX_SERIAL2   = 6'h05;
  localparam logic [5:0] IDX_SERIAL1   = 6'h06;
  localparam logic [5:0] IDX_SERIAL0   = 6'h07;
  localparam logic [5:0] IDX_X_MSB     = 6'h08;
  localparam logic [5:0] IDX_Y_MSB     = 6'h09;
  localparam logic [5:0] IDX_Z_MSB     = 6'h0A;
  localparam logic [5:0] IDX_STATUS    = 6'h0B;
  localparam logic [5:0] IDX_CTRL      = 6'h20;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h21;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h22;

  // status bit positions
  localparam int ST_UPSET    = 7;
  localparam int ST_AWAKE    = 6;
  localparam int ST_STILL    = 5;
  localparam int ST_MOTION   = 4;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_LEVEL    = 2;
  localparam int ST_READY    = 1;
  localparam int ST_DATA_RDY = 0;
  localparam logic [7:0] STATUS_RESET = 8'h40;

  // interrupt status / mask bit positions
  localparam int IRQ_DATA    = 0;
  localparam int IRQ_MOTION  = 1;
  localparam int IRQ_STILL   = 2;
  localparam int IRQ_UPSET   = 3;
  localparam int IRQ_OVERRUN = 4;
  localparam int IRQ_W       = 5;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_THR_LSB  = 8;
  localparam int QCNT_W        = 10;
  localparam logic [1:0] MODE_DEFAULT = 2'h0;
  localparam logic [1:0] MODE_LINKED  = 2'h1;
  localparam logic [1:0] MODE_LOOP    = 2'h3;

  // sample field
  localparam int SAMPLE_W  = 14;
  localparam int MSB_LSB   = 6;
  localparam int SERIAL_W  = 31;

  // address index and serial byte positions
  localparam int ADR_IDX_LSB = 2;
  localparam int IDX_W       = 6;
  localparam int BYTE_W      = 8;
  localparam int MODE_W      = 2;
  localparam int SER_TOP_LSB = 24;
  localparam int SER_TOP_W   = 4;
  localparam int SER_HI_LSB  = 16;
  localparam int SER_MID_LSB = 8;
  localparam int SER_LO_LSB  = 0;

  typedef struct packed {
    logic [SAMPLE_W-1:0] x;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] z;
  } asr_sample_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } asr_bus_state_t;

endpackage : asr_pkg

// ---- verilog/asr_regs.sv ----
/*
  asr_regs: read-only serial, sample and status register bank of a three-axis
  motion sensor, with a wishbone classic slave, interrupt status and mask.
  assumes: all event and level inputs come from logic on ref_clk; serial
  number input is stable; one answer per request, ack one cycle after it.
*/
// Notes on behaviour
// (RULE_01) Serial number bits 23..0 are three read-only bytes at 0x05..0x07, most significant first.
// (RULE_02) Serial bits 27..24 sit in the low nibble at 0x04, the upper nibble reads zero.
// (RULE_03) Address 0x08 returns bits 13..6 of the latest x sample.
// (RULE_04) Address 0x09 returns bits 13..6 of the latest y sample.
// (RULE_05) Address 0x0A returns bits 13..6 of the latest z sample.
// (RULE_06) A host needing only 8 bits should read one byte per axis instead of two.
// (RULE_07) Status bit 7 flags a configuration upset or an unconfigured device.
// (RULE_08) The upset flag is set at reset and clears on any register write.
// (RULE_09) Status bit 6 shows the awake state, 1 active and 0 inactive.
// (RULE_10) Awake resets to 1 and follows detection only in linked or loop mode, else stays 1.
// (RULE_11) Status bit 5 is set on an inactivity or free-fall detection.
// (RULE_12) Status bit 4 is set on an over-threshold activity detection.
// (RULE_13) The status register resets to 0x40; here it reads 0xC0, as reset also raises the upset flag.
// (RULE_14) Status bit 3 flags queue overrun, and while set no new sample enters the queue; here queue_write_block follows it one cycle late.
// (RULE_15) Bit 2 is set when the queue holds more than the threshold, bit 1 when it is not empty.
// (RULE_16) Bit 0 flags a new sample, clears on a data read and is not set during one.
// (RULE_17) Writes to the read-only addresses change nothing except clearing the upset flag.
`timescale 1ns/1ps

module asr_regs #(
  parameter int                    ADR_W        = 8,
  parameter logic [asr_pkg::QCNT_W-1:0] THR_RESET = 10'h000
) (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  // wishbone classic slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [ADR_W-1:0]             wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  // unit identity
  input  wire logic [asr_pkg::SERIAL_W-1:0] serial_number,
  // sample path
  input  wire logic                         sample_valid,
  input  wire asr_pkg::asr_sample_t         sample_in,
  // detection engines
  input  wire logic                         config_upset,
  input  wire logic                         awake_state,
  input  wire logic                         stillness_detected,
  input  wire logic                         motion_detected,
  // sample queue
  input  wire logic                         queue_overrun,
  input  wire logic [asr_pkg::QCNT_W-1:0]   queue_count,
  output logic                              queue_write_block,
  output logic [1:0]                        detect_coupling_mode,
  // interrupt
  output logic                              irq
);

  typedef struct packed {
    asr_pkg::asr_bus_state_t     bus;
    logic [31:0]                 rdata;
    logic [7:0]                  x_msb;
    logic [7:0]                  y_msb;
    logic [7:0]                  z_msb;
    logic                        upset;
    logic                        still;
    logic                        motion;
    logic                        data_rdy;
    logic                        rdy_pend;
    logic [1:0]                  mode;
    logic [asr_pkg::QCNT_W-1:0]  thr;
    logic [asr_pkg::IRQ_W-1:0]   irq_stat;
    logic [asr_pkg::IRQ_W-1:0]   irq_mask;
    logic                        irq;
    logic                        qblock;
    logic                        ovr_d;
  } asr_state_t;

  asr_state_t st_ff;
  asr_state_t nxt_st;

  logic       req;
  logic [5:0] idx;
  logic       data_rd;
  logic       wr;
  logic [7:0] status;
  logic       awake_shown;
  logic [asr_pkg::IRQ_W-1:0] evt;

  assign req     = wb_cyc_i & wb_stb_i & (st_ff.bus == asr_pkg::BUS_IDLE);
  assign idx     = wb_adr_i[asr_pkg::ADR_IDX_LSB +: asr_pkg::IDX_W];
  assign wr      = req & wb_we_i;
  assign data_rd = wb_cyc_i & wb_stb_i & ~wb_we_i &
                   (idx >= asr_pkg::IDX_X_MSB) & (idx <= asr_pkg::IDX_Z_MSB);

  // status byte assembly
  always_comb begin
    // (RULE_10) awake only in coupled modes
    awake_shown = ((st_ff.mode == asr_pkg::MODE_LINKED) || (st_ff.mode == asr_pkg::MODE_LOOP)) ?
                  awake_state : 1'b1;
    status = 8'h00;
    // (RULE_07) upset flag on bit 7
    status[asr_pkg::ST_UPSET]    = st_ff.upset;
    // (RULE_09) awake state bit
    status[asr_pkg::ST_AWAKE]    = awake_shown;
    // (RULE_11) stillness bit
    status[asr_pkg::ST_STILL]    = st_ff.still;
    // (RULE_12) motion bit
    status[asr_pkg::ST_MOTION]   = st_ff.motion;
    // (RULE_14) overrun bit
    status[asr_pkg::ST_OVERRUN]  = queue_overrun;
    // (RULE_15) level and ready bits
    status[asr_pkg::ST_LEVEL]    = queue_count > st_ff.thr;
    status[asr_pkg::ST_READY]    = queue_count != '0;
    // (RULE_16) data ready bit
    status[asr_pkg::ST_DATA_RDY] = st_ff.data_rdy;
  end

  // interrupt events
  always_comb begin
    evt = '0;
    evt[asr_pkg::IRQ_DATA]    = sample_valid;
    evt[asr_pkg::IRQ_MOTION]  = motion_detected;
    evt[asr_pkg::IRQ_STILL]   = stillness_detected;
    evt[asr_pkg::IRQ_UPSET]   = config_upset;
    evt[asr_pkg::IRQ_OVERRUN] = queue_overrun & ~st_ff.ovr_d;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ovr_d = queue_overrun;

    // bus handshake: answer one cycle after the request, drop ack next cycle
    case (st_ff.bus)
      asr_pkg::BUS_IDLE: begin
        if (req) begin
          nxt_st.bus = asr_pkg::BUS_ACK;
        end
      end
      asr_pkg::BUS_ACK: begin
        nxt_st.bus = asr_pkg::BUS_IDLE;
      end
      default: begin
        nxt_st.bus = asr_pkg::BUS_IDLE;
      end
    endcase

    // read data mux, unmapped reads as zero
    nxt_st.rdata = 32'h0000_0000;
    if (req & ~wb_we_i) begin
      case (idx)
        // (RULE_02) top serial nibble
        asr_pkg::IDX_SERIAL3:  nxt_st.rdata = {28'h000_0000, serial_number[asr_pkg::SER_TOP_LSB +: asr_pkg::SER_TOP_W]};
        // (RULE_01) serial bytes msb first
        asr_pkg::IDX_SERIAL2:  nxt_st.rdata = {24'h00_0000, serial_number[asr_pkg::SER_HI_LSB +: asr_pkg::BYTE_W]};
        asr_pkg::IDX_SERIAL1:  nxt_st.rdata = {24'h00_0000, serial_number[asr_pkg::SER_MID_LSB +: asr_pkg::BYTE_W]};
        asr_pkg::IDX_SERIAL0:  nxt_st.rdata = {24'h00_0000, serial_number[asr_pkg::SER_LO_LSB +: asr_pkg::BYTE_W]};
        // (RULE_03) x high byte
        asr_pkg::IDX_X_MSB:    nxt_st.rdata = {24'h00_0000, st_ff.x_msb};
        // (RULE_04) y high byte
        asr_pkg::IDX_Y_MSB:    nxt_st.rdata = {24'h00_0000, st_ff.y_msb};
        // (RULE_05) z high byte
        asr_pkg::IDX_Z_MSB:    nxt_st.rdata = {24'h00_0000, st_ff.z_msb};
        asr_pkg::IDX_STATUS:   nxt_st.rdata = {24'h00_0000, status};
        asr_pkg::IDX_CTRL:     nxt_st.rdata = {14'h0000, st_ff.thr, 6'h00, st_ff.mode};
        asr_pkg::IDX_IRQ_STAT: nxt_st.rdata = {27'h000_0000, st_ff.irq_stat};
        asr_pkg::IDX_IRQ_MASK: nxt_st.rdata = {27'h000_0000, st_ff.irq_mask};
        default:               nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    // (RULE_03) latch the top bits of each axis
    if (sample_valid) begin
      nxt_st.x_msb = sample_in.x[asr_pkg::SAMPLE_W-1:asr_pkg::MSB_LSB];
      nxt_st.y_msb = sample_in.y[asr_pkg::SAMPLE_W-1:asr_pkg::MSB_LSB];
      nxt_st.z_msb = sample_in.z[asr_pkg::SAMPLE_W-1:asr_pkg::MSB_LSB];
    end

    // (RULE_16) hold data ready off during a data read, set it after
    if (data_rd) begin
      nxt_st.data_rdy = 1'b0;
      if (sample_valid) begin
        nxt_st.rdy_pend = 1'b1;
      end
      if (st_ff.bus == asr_pkg::BUS_ACK) begin
        nxt_st.data_rdy = st_ff.rdy_pend | sample_valid;
        nxt_st.rdy_pend = 1'b0;
      end
    end else if (sample_valid) begin
      nxt_st.data_rdy = 1'b1;
    end

    // (RULE_11) stillness sticky until status read, set wins
    // (RULE_12) motion sticky until status read, set wins
    if (req & ~wb_we_i & (idx == asr_pkg::IDX_STATUS)) begin
      nxt_st.still  = 1'b0;
      nxt_st.motion = 1'b0;
    end
    if (stillness_detected) begin
      nxt_st.still = 1'b1;
    end
    if (motion_detected) begin
      nxt_st.motion = 1'b1;
    end

    // (RULE_08) any write clears the upset flag, a new upset wins
    // (RULE_17) writes to read-only addresses store nothing
    if (wr) begin
      nxt_st.upset = 1'b0;
      if ((idx == asr_pkg::IDX_CTRL) && wb_sel_i[0]) begin
        nxt_st.mode = wb_dat_i[asr_pkg::CTRL_MODE_LSB +: asr_pkg::MODE_W];
      end
      if ((idx == asr_pkg::IDX_CTRL) && wb_sel_i[1] && wb_sel_i[2]) begin
        nxt_st.thr = wb_dat_i[asr_pkg::CTRL_THR_LSB +: asr_pkg::QCNT_W];
      end
      if ((idx == asr_pkg::IDX_IRQ_MASK) && wb_sel_i[0]) begin
        nxt_st.irq_mask = wb_dat_i[asr_pkg::IRQ_W-1:0];
      end
      if ((idx == asr_pkg::IDX_IRQ_STAT) && wb_sel_i[0]) begin
        nxt_st.irq_stat = st_ff.irq_stat & ~wb_dat_i[asr_pkg::IRQ_W-1:0];
      end
    end
    // (RULE_07) upset event sets the flag
    if (config_upset) begin
      nxt_st.upset = 1'b1;
    end

    // sticky interrupt bits, set wins over write-one-clear
    nxt_st.irq_stat = nxt_st.irq_stat | evt;
    nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_mask);

    // (RULE_14) block queue writes from the cycle after overrun rises to the cycle after it falls
    nxt_st.qblock = queue_overrun;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_ff          <= '0;
      st_ff.bus      <= asr_pkg::BUS_IDLE;
      // (RULE_13) status reads 0xC0 after reset: awake bit 0x40 plus the upset flag raised by reset
      // (RULE_08) reset raises the upset flag
      st_ff.upset    <= 1'b1;
      st_ff.mode     <= asr_pkg::MODE_DEFAULT;
      st_ff.thr      <= THR_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign wb_ack_o             = (st_ff.bus == asr_pkg::BUS_ACK);
  assign wb_dat_o             = st_ff.rdata;
  assign queue_write_block    = st_ff.qblock;
  assign detect_coupling_mode = st_ff.mode;
  assign irq                  = st_ff.irq;

endmodule : asr_regs
